// ===== logic/sfl_cfg.svh
// Constants of the serial flash command sequencer
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH
`define SFL_OP_READ 8'h03
`define SFL_OP_FAST 8'h0B
`define SFL_OP_PAGE 8'h02
`define SFL_OP_SECT 8'hD8
`define SFL_OP_BULK 8'hC7
`define SFL_OP_UNLOCK 8'h06
`define SFL_AW 18
`define SFL_PAGE_AW 8
`define SFL_BIT_LAST 3'h7
`define SFL_ADDR_LAST 2'h2
`define SFL_ERASED 8'hFF
`define SFL_PROG_LAST 19'h00100
`define SFL_SECT_LAST 19'h0FFFF
`define SFL_BULK_LAST 19'h3FFFF
`define SFL_SECT_LOW 16'h0000
`define SFL_TOP_SECT 2'h3
`endif

// ===== logic/sfl_pkg.sv
// Types of the serial flash command sequencer
package sfl_pkg;
  // Frame decoding states
  typedef enum logic [2:0] {
    SFL_F_IDLE,
    SFL_F_OPC,
    SFL_F_ADDR,
    SFL_F_DUMMY,
    SFL_F_RD,
    SFL_F_PDATA,
    SFL_F_ARMED,
    SFL_F_SKIP
  } sfl_frame_e;
  // Self-timed cycle states
  typedef enum logic [1:0] {
    SFL_E_IDLE,
    SFL_E_PROG,
    SFL_E_ERASE
  } sfl_eng_e;
endpackage

// ===== logic/sfl_mem.sv
// Byte memory with registered read and plain or bit-clearing write
`timescale 1ns/10ps
module sfl_mem #(
  parameter int AW = 8
) (
  // Clocking
  input wire logic core_clk,
  input wire logic clk_en,
  // Port
  input wire logic [AW-1:0] addr,
  input wire logic we,
  input wire logic and_mode,
  input wire logic [7:0] wd,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Contents hold no reset; an AND write can only clear bits
  always_ff @(posedge core_clk)
  begin
    if (clk_en)
    begin
      if (we)
      begin
        mem[addr] <= and_mode ? (mem[addr] & wd) : wd;
      end
      rdata <= mem[addr];
    end
  end
endmodule

// ===== logic/sfl_core.sv
// Serial flash read, program and erase sequencer
`timescale 1ns/10ps
`include "sfl_cfg.svh"
module sfl_core
  import sfl_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Serial link pins
  input wire logic sel_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  // Protection setting
  input wire logic guard_size_hi,
  input wire logic guard_size_lo,
  // Status
  output logic busy_cycle_flag,
  output logic write_unlock_latch
);
  logic sel_m_reg;
  logic sel_s_reg;
  logic sel_d_reg;
  logic sck_m_reg;
  logic sck_s_reg;
  logic sck_d_reg;
  logic mosi_m_reg;
  logic mosi_s_reg;
  logic sck_rise;
  logic sck_fall;
  logic sel_rise;
  logic sel_fall;
  sfl_frame_e state_reg;
  sfl_eng_e eng_reg;
  logic [7:0] cmd_reg;
  logic [7:0] sh_in_reg;
  logic [7:0] byte_in;
  logic [2:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic byte_done;
  logic [`SFL_AW-1:0] addr_reg;
  logic [`SFL_AW-1:0] new_addr;
  logic [6:0] out_sh_reg;
  logic [2:0] out_cnt_reg;
  logic miso_reg;
  logic miso_oe_reg;
  logic [7:0] col_reg;
  logic [9:0] page_reg;
  logic [255:0] valid_reg;
  logic got_byte_reg;
  logic buf_we_reg;
  logic [7:0] buf_wa_reg;
  logic [7:0] buf_wd_reg;
  logic wel_reg;
  logic busy_reg;
  logic [18:0] eng_cnt_reg;
  logic [18:0] eng_last_reg;
  logic [`SFL_AW-1:0] eng_base_reg;
  logic [1:0] guard;
  logic pp_armed;
  logic do_unlock;
  logic do_pp;
  logic do_se;
  logic do_be;
  logic [7:0] prog_col;
  logic [`SFL_AW-1:0] arr_addr;
  logic arr_we;
  logic arr_and;
  logic [7:0] arr_wd;
  logic [7:0] arr_rdata;
  logic [7:0] buf_addr;
  logic buf_we;
  logic [7:0] buf_rdata;

  // True when the guard setting covers the given sector
  function automatic logic guarded(input logic [1:0] bp,
                                   input logic [1:0] sec);
    logic hit;
    hit = 1'b0;
    unique case (bp)
      2'h0: hit = 1'b0;
      2'h1: hit = (sec == `SFL_TOP_SECT);
      2'h2: hit = sec[1];
      2'h3: hit = 1'b1;
    endcase
    return hit;
  endfunction

  // Pins cross two flops before any logic looks at them
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sel_m_reg <= 1'b1;
      sel_s_reg <= 1'b1;
      sel_d_reg <= 1'b1;
      sck_m_reg <= 1'b0;
      sck_s_reg <= 1'b0;
      sck_d_reg <= 1'b0;
      mosi_m_reg <= 1'b0;
      mosi_s_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      sel_m_reg <= sel_n;
      sel_s_reg <= sel_m_reg;
      sel_d_reg <= sel_s_reg;
      sck_m_reg <= sclk;
      sck_s_reg <= sck_m_reg;
      sck_d_reg <= sck_s_reg;
      mosi_m_reg <= mosi;
      mosi_s_reg <= mosi_m_reg;
    end
  end

  // Clock edge events seen only while selected; select edges always
  assign sck_rise = sck_s_reg & ~sck_d_reg & ~sel_s_reg;
  assign sck_fall = ~sck_s_reg & sck_d_reg & ~sel_s_reg;
  assign sel_rise = sel_s_reg & ~sel_d_reg;
  assign sel_fall = ~sel_s_reg & sel_d_reg;
  assign byte_in = {sh_in_reg[6:0], mosi_s_reg};
  assign byte_done = sck_rise && (bit_cnt_reg == `SFL_BIT_LAST);
  assign new_addr = {addr_reg[`SFL_AW-2:0], mosi_s_reg};
  assign guard = {guard_size_hi, guard_size_lo};

  // Input shifter and bit and byte counters
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sh_in_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
      byte_cnt_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      if (sel_fall)
      begin
        bit_cnt_reg <= 3'h0;
        byte_cnt_reg <= 2'h0;
      end
      else if (sck_rise)
      begin
        sh_in_reg <= byte_in;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (byte_done && state_reg == SFL_F_ADDR)
        begin
          byte_cnt_reg <= byte_cnt_reg + 2'h1;
        end
      end
    end
  end

  // Frame decoder; a select rise always returns to idle
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= SFL_F_IDLE;
      cmd_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      if (sel_s_reg)
      begin
        state_reg <= SFL_F_IDLE;
      end
      else if (sel_fall)
      begin
        state_reg <= SFL_F_OPC;
      end
      else if (sck_rise)
      begin
        unique case (state_reg)
          SFL_F_OPC:
          begin
            if (byte_done)
            begin
              cmd_reg <= byte_in;
              case (byte_in)
                `SFL_OP_READ, `SFL_OP_FAST:
                  state_reg <= busy_reg ? SFL_F_SKIP : SFL_F_ADDR;
                `SFL_OP_PAGE, `SFL_OP_SECT:
                  state_reg <= (busy_reg || !wel_reg) ? SFL_F_SKIP
                                                      : SFL_F_ADDR;
                `SFL_OP_BULK, `SFL_OP_UNLOCK:
                  state_reg <= busy_reg ? SFL_F_SKIP : SFL_F_ARMED;
                default:
                  state_reg <= SFL_F_SKIP;
              endcase
            end
          end
          SFL_F_ADDR:
          begin
            if (byte_done && byte_cnt_reg == `SFL_ADDR_LAST)
            begin
              case (cmd_reg)
                `SFL_OP_READ: state_reg <= SFL_F_RD;
                `SFL_OP_FAST: state_reg <= SFL_F_DUMMY;
                `SFL_OP_PAGE: state_reg <= SFL_F_PDATA;
                default: state_reg <= SFL_F_ARMED;
              endcase
            end
          end
          SFL_F_DUMMY:
          begin
            if (byte_done)
            begin
              state_reg <= SFL_F_RD;
            end
          end
          // Any further clock after a complete short command kills it
          SFL_F_ARMED: state_reg <= SFL_F_SKIP;
          SFL_F_IDLE, SFL_F_RD, SFL_F_PDATA, SFL_F_SKIP:
            state_reg <= state_reg;
        endcase
      end
    end
  end

  // Address capture, and read stepping as each byte starts out
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_reg <= '0;
    end
    else if (clk_en)
    begin
      if (sck_rise && state_reg == SFL_F_ADDR)
      begin
        addr_reg <= new_addr;
      end
      else if (sck_fall && state_reg == SFL_F_RD && out_cnt_reg == 3'h0)
      begin
        addr_reg <= addr_reg + 18'h00001;
      end
    end
  end

  // Read data leaves on falling clock edges, MSB first
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_sh_reg <= 7'h00;
      out_cnt_reg <= 3'h0;
      miso_reg <= 1'b0;
      miso_oe_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (sel_s_reg)
      begin
        out_cnt_reg <= 3'h0;
        miso_oe_reg <= 1'b0;
      end
      else if (sck_fall && state_reg == SFL_F_RD)
      begin
        miso_oe_reg <= 1'b1;
        out_cnt_reg <= out_cnt_reg + 3'h1;
        if (out_cnt_reg == 3'h0)
        begin
          miso_reg <= arr_rdata[7];
          out_sh_reg <= arr_rdata[6:0];
        end
        else
        begin
          miso_reg <= out_sh_reg[6];
          out_sh_reg <= {out_sh_reg[5:0], 1'b0};
        end
      end
    end
  end

  // Page data lands in a staging buffer; later bytes overwrite.
  // A frame refused while busy must not wipe the running byte map.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      col_reg <= 8'h00;
      page_reg <= 10'h000;
      valid_reg <= '0;
      got_byte_reg <= 1'b0;
      buf_we_reg <= 1'b0;
      buf_wa_reg <= 8'h00;
      buf_wd_reg <= 8'h00;
    end
    else if (clk_en)
    begin
      buf_we_reg <= 1'b0;
      if (sel_fall && !busy_reg)
      begin
        valid_reg <= '0;
        got_byte_reg <= 1'b0;
      end
      else if (byte_done && state_reg == SFL_F_ADDR &&
               byte_cnt_reg == `SFL_ADDR_LAST)
      begin
        col_reg <= new_addr[7:0];
        page_reg <= new_addr[`SFL_AW-1:`SFL_PAGE_AW];
      end
      else if (byte_done && state_reg == SFL_F_PDATA)
      begin
        buf_we_reg <= 1'b1;
        buf_wa_reg <= col_reg;
        buf_wd_reg <= byte_in;
        valid_reg[col_reg] <= 1'b1;
        col_reg <= col_reg + 8'h01;
        got_byte_reg <= 1'b1;
      end
    end
  end

  // Commands execute only on a select rise at the right bit
  assign pp_armed = (state_reg == SFL_F_PDATA) && got_byte_reg &&
                    (bit_cnt_reg == 3'h0);
  assign do_unlock = sel_rise && state_reg == SFL_F_ARMED &&
                     cmd_reg == `SFL_OP_UNLOCK && !busy_reg;
  assign do_pp = sel_rise && pp_armed &&
                 !guarded(guard, page_reg[9:8]);
  assign do_se = sel_rise && state_reg == SFL_F_ARMED &&
                 cmd_reg == `SFL_OP_SECT &&
                 !guarded(guard, addr_reg[17:16]);
  assign do_be = sel_rise && state_reg == SFL_F_ARMED &&
                 cmd_reg == `SFL_OP_BULK && wel_reg && !busy_reg &&
                 guard == 2'h0;

  // Unlock latch; cleared when a write cycle is launched
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wel_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (do_unlock)
      begin
        wel_reg <= 1'b1;
      end
      else if (do_pp || do_se || do_be)
      begin
        wel_reg <= 1'b0;
      end
    end
  end

  // Self-timed cycle: walks the page or the erase range
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eng_reg <= SFL_E_IDLE;
      busy_reg <= 1'b0;
      eng_cnt_reg <= 19'h00000;
      eng_last_reg <= 19'h00000;
      eng_base_reg <= '0;
    end
    else if (clk_en)
    begin
      unique case (eng_reg)
        SFL_E_IDLE:
        begin
          eng_cnt_reg <= 19'h00000;
          if (do_pp)
          begin
            eng_reg <= SFL_E_PROG;
            busy_reg <= 1'b1;
          end
          else if (do_se || do_be)
          begin
            eng_reg <= SFL_E_ERASE;
            busy_reg <= 1'b1;
            eng_base_reg <= do_se ? {addr_reg[17:16], `SFL_SECT_LOW}
                                  : '0;
            eng_last_reg <= do_se ? `SFL_SECT_LAST : `SFL_BULK_LAST;
          end
        end
        SFL_E_PROG:
        begin
          eng_cnt_reg <= eng_cnt_reg + 19'h00001;
          if (eng_cnt_reg == `SFL_PROG_LAST)
          begin
            eng_reg <= SFL_E_IDLE;
            busy_reg <= 1'b0;
          end
        end
        SFL_E_ERASE:
        begin
          eng_cnt_reg <= eng_cnt_reg + 19'h00001;
          if (eng_cnt_reg == eng_last_reg)
          begin
            eng_reg <= SFL_E_IDLE;
            busy_reg <= 1'b0;
          end
        end
      endcase
    end
  end

  // Buffer read runs one step ahead of the array write
  assign prog_col = eng_cnt_reg[7:0] - 8'h01;

  // Array and buffer port steering
  always_comb
  begin
    arr_addr = addr_reg;
    arr_we = 1'b0;
    arr_and = 1'b0;
    arr_wd = `SFL_ERASED;
    buf_addr = buf_wa_reg;
    buf_we = buf_we_reg;
    unique case (eng_reg)
      SFL_E_PROG:
      begin
        buf_addr = eng_cnt_reg[7:0];
        buf_we = 1'b0;
        arr_addr = {page_reg, prog_col};
        arr_we = (eng_cnt_reg != 19'h00000) && valid_reg[prog_col];
        arr_and = 1'b1;
        arr_wd = buf_rdata;
      end
      SFL_E_ERASE:
      begin
        arr_addr = eng_base_reg + eng_cnt_reg[`SFL_AW-1:0];
        arr_we = 1'b1;
      end
      SFL_E_IDLE:
      begin
        arr_addr = addr_reg;
      end
    endcase
  end

  // Main array, 18-bit byte addressed
  sfl_mem #(.AW(`SFL_AW)) u_array (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .addr(arr_addr),
    .we(arr_we),
    .and_mode(arr_and),
    .wd(arr_wd),
    .rdata(arr_rdata)
  );

  // Page staging buffer
  sfl_mem #(.AW(`SFL_PAGE_AW)) u_page_buf (
    .core_clk(core_clk),
    .clk_en(clk_en),
    .addr(buf_addr),
    .we(buf_we),
    .and_mode(1'b0),
    .wd(buf_wd_reg),
    .rdata(buf_rdata)
  );

  // Outputs straight from flops
  assign miso = miso_reg;
  assign miso_oe = miso_oe_reg;
  assign busy_cycle_flag = busy_reg;
  assign write_unlock_latch = wel_reg;
endmodule

// ===== tb/sfl_core_assertions.sv
// Port checker of the serial flash sequencer
`timescale 1ns/10ps
module sfl_core_chk (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Link pins
  input wire logic sel_n,
  input wire logic miso_oe,
  // Status
  input wire logic busy_cycle_flag,
  input wire logic write_unlock_latch
);
  logic [18:0] busy_cnt_reg;
  default clocking dc @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  // Length of the running cycle; 19 bits hold a bulk erase
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      busy_cnt_reg <= 19'h00000;
    else if (busy_cycle_flag)
      busy_cnt_reg <= busy_cnt_reg + 19'h00001;
    else
      busy_cnt_reg <= 19'h00000;
  end
  a_latch_before_busy: assert property (
    $rose(busy_cycle_flag) |-> $past(write_unlock_latch, 2))
    else $error("cycle began without unlock");
  a_busy_after_sel: assert property (
    $rose(busy_cycle_flag) |-> sel_n && $past(sel_n, 2))
    else $error("cycle began while selected");
  a_busy_min_len: assert property (
    $fell(busy_cycle_flag) |-> busy_cnt_reg >= 19'h00100)
    else $error("cycle too short");
  a_busy_max_len: assert property (
    busy_cycle_flag |-> busy_cnt_reg <= 19'h40001)
    else $error("cycle too long");
  a_latch_clear_busy: assert property (
    busy_cycle_flag && $past(busy_cycle_flag, 2) |-> !write_unlock_latch)
    else $error("latch still set in cycle");
  a_oe_deselect: assert property (
    sel_n [*6] |-> !miso_oe)
    else $error("output kept after deselect");
  a_busy_no_oe: assert property (
    busy_cycle_flag |-> !miso_oe)
    else $error("read served while busy");
  a_latch_set_idle: assert property (
    $rose(write_unlock_latch) |-> sel_n && !busy_cycle_flag)
    else $error("latch set at wrong time");
  // Main scenarios reached
  c_cycle: cover property ($rose(busy_cycle_flag));
  c_read: cover property ($rose(miso_oe));
  c_done: cover property ($fell(busy_cycle_flag));
endmodule
bind sfl_core sfl_core_chk chk (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .sel_n(sel_n),
  .miso_oe(miso_oe),
  .busy_cycle_flag(busy_cycle_flag),
  .write_unlock_latch(write_unlock_latch)
);

// ===== tb/sfl_host.sv
// Link master model driving select, clock and data
`timescale 1ns/10ps
module sfl_host (
  // Link pins
  output logic sel_n,
  output logic sclk,
  output logic mosi,
  input wire logic miso,
  // Byte taken in, valid at rx_ev
  output logic [7:0] rx_byte
);
  event rx_ev;
  // Deselected, clock parked low between frames
  initial
  begin
    sel_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    rx_byte = 8'h00;
  end
  // Command bytes, nrd read bytes, then loose bits
  task automatic frame(input logic [7:0] tx [$], input int nrd,
    input int loose);
    int nc;
    int nb;
    nc = tx.size() * 8;
    nb = nc + nrd * 8 + loose;
    sel_n = 1'b0;
    #400;
    for (int i = 0; i < nb; i++)
    begin
      // Filler toggles so no stale level sits on the line
      mosi = (i < nc) ? tx[i / 8][7 - i % 8] : ~mosi;
      #400;
      sclk = 1'b1;
      // Sampled late: the pins pass a synchroniser
      #390;
      rx_byte = {rx_byte[6:0], miso};
      if (i >= nc && i < nc + nrd * 8 && i % 8 == 7)
        -> rx_ev;
      #10;
      sclk = 1'b0;
    end
    #400;
    sel_n = 1'b1;
    mosi = ~mosi;
    #1000;
  endtask
endmodule

// ===== tb/sfl_core_tb.sv
// Bench of the serial flash sequencer
`timescale 1ns/10ps
module sfl_core_tb;
  `define CHK(g, w) \
  begin \
    checks_done++; \
    if ((g) !== (w)) \
    begin \
      failures++; \
      $display("wrong value at %0t: %h not %h", $time, g, w); \
    end \
  end
  logic core_clk;
  logic rst_n;
  logic guard_size_hi;
  logic guard_size_lo;
  logic sel_n;
  logic sclk;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic busy;
  logic latch;
  logic oe_seen;
  logic [7:0] rx_byte;
  logic [7:0] ev;
  logic [7:0] d [0:256];
  logic [7:0] txq [$];
  logic [7:0] exp_q [$];
  int failures;
  int checks_done;
  int seed;
  sfl_core uut (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(1'b1),
    .sel_n(sel_n),
    .sclk(sclk),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .guard_size_hi(guard_size_hi),
    .guard_size_lo(guard_size_lo),
    .busy_cycle_flag(busy),
    .write_unlock_latch(latch)
  );
  sfl_host host (
    .sel_n(sel_n),
    .sclk(sclk),
    .mosi(mosi),
    .miso(miso),
    .rx_byte(rx_byte)
  );
  initial
    core_clk = 1'b0;
  always #50 core_clk = ~core_clk;
  // Any output enable seen at all
  always @(posedge core_clk)
    if (miso_oe === 1'b1)
      oe_seen <= 1'b1;
  // Oldest note against each byte taken in
  always @(host.rx_ev)
  begin
    // Let the port copy of the byte settle before looking
    #1;
    if (exp_q.size() == 0)
    begin
      failures++;
      $display("wrong value at %0t: byte not expected", $time);
    end
    else
    begin
      ev = exp_q.pop_front();
      `CHK(rx_byte, ev)
    end
  end
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic go(input int nrd, input int loose);
    @(posedge core_clk);
    #5;
    host.frame(txq, nrd, loose);
    txq = {};
  endtask
  task automatic acmd(input logic [7:0] op, input logic [23:0] a);
    txq = {op, a[23:16], a[15:8], a[7:0]};
  endtask
  task automatic unlock();
    txq = {8'h06};
    go(0, 0);
  endtask
  // Bounded wait for the end of a cycle
  task automatic idle(input int lim);
    int n;
    n = 0;
    while (busy !== 1'b0 && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    if (n >= lim)
    begin
      failures++;
      $display("wrong value at %0t: still busy", $time);
      report_and_stop();
    end
  endtask
  initial
  begin
    failures = 0;
    checks_done = 0;
    seed = 6488;
    oe_seen = 1'b0;
    rst_n = 1'b0;
    guard_size_hi = 1'b0;
    guard_size_lo = 1'b0;
    for (int i = 0; i < 257; i++)
      d[i] = $random(seed);
    repeat (3) @(posedge core_clk);
    #5;
    rst_n = 1'b1;
    `CHK(busy, 1'b0)
    `CHK(latch, 1'b0)
    // Erase with the latch clear must not start
    acmd(8'hD8, 24'h000000);
    go(0, 0);
    `CHK(busy, 1'b0)
    unlock();
    `CHK(latch, 1'b1)
    // Guard 01 covers sector 3 and blocks bulk erase
    guard_size_lo = 1'b1;
    acmd(8'hD8, 24'h03ABCD);
    go(0, 0);
    `CHK(busy, 1'b0)
    txq = {8'hC7};
    go(0, 0);
    `CHK(busy, 1'b0)
    guard_size_lo = 1'b0;
    // One extra clock spoils the erase
    acmd(8'hD8, 24'h000000);
    go(0, 1);
    `CHK(latch, 1'b1)
    // Junk top bits still pick sector 0
    acmd(8'hD8, 24'hFC1234);
    go(0, 0);
    `CHK(busy, 1'b1)
    `CHK(latch, 1'b0)
    acmd(8'h03, 24'h000000);
    go(0, 16);
    `CHK(oe_seen, 1'b0)
    idle(70000);
    // Program past the page end wraps to its start
    unlock();
    acmd(8'h02, 24'h0000FE);
    txq = {txq, d[0], d[1], d[2]};
    go(0, 0);
    // A read tried during programming must leave the cycle intact
    txq = {8'h0B};
    go(0, 0);
    idle(400);
    exp_q = {d[2], 8'hFF};
    acmd(8'h03, 24'hFC0000);
    go(2, 0);
    exp_q = {d[0], d[1], 8'hFF};
    acmd(8'h03, 24'h0000FE);
    go(3, 3);
    `CHK(miso_oe, 1'b0)
    // Second program only clears bits
    unlock();
    acmd(8'h02, 24'h0000FE);
    txq.push_back(d[3]);
    go(0, 0);
    idle(400);
    exp_q = {d[0] & d[3], d[1]};
    acmd(8'h0B, 24'h0000FE);
    txq.push_back(8'h5A);
    go(2, 0);
    // Program cut inside a byte is dropped
    unlock();
    acmd(8'h02, 24'h000010);
    txq.push_back(d[4]);
    go(0, 3);
    `CHK(busy, 1'b0)
    // 257 bytes: the last overwrites the first
    acmd(8'h02, 24'h000200);
    for (int i = 0; i < 257; i++)
      txq.push_back(d[i]);
    go(0, 0);
    idle(400);
    exp_q = {d[256], d[1]};
    acmd(8'h03, 24'h000200);
    go(2, 0);
    // Guarded page refused, then a zero byte at the top of the array
    unlock();
    guard_size_lo = 1'b1;
    acmd(8'h02, 24'h03FFFF);
    txq.push_back(8'h00);
    go(0, 0);
    `CHK(busy, 1'b0)
    `CHK(latch, 1'b1)
    guard_size_lo = 1'b0;
    acmd(8'h02, 24'h03FFFF);
    txq.push_back(8'h00);
    go(0, 0);
    idle(400);
    // Clearing an unerased byte to zero makes it known for the wrap
    exp_q = {8'h00, d[2]};
    acmd(8'h03, 24'h03FFFF);
    go(2, 0);
    `CHK(exp_q.size(), 0)
    report_and_stop();
  end
endmodule
